// *** osm_defines.svh ***
/*
  Constants of the subcarrier mapper: tone positions, counts, pilot patterns,
  the length-127 sign sequence and the initial values of the tone counters.
  Assumes it is included once per compilation unit, by its bare name.
*/
`ifndef OSM_DEFINES_SVH
`define OSM_DEFINES_SVH

// ----------------------------------------------------------------------------
// tone layout
// ----------------------------------------------------------------------------
`define OSM_N_DATA       100
`define OSM_DATA_LAST    7'h63
`define OSM_TONE_LO      8'shC3
`define OSM_TONE_HI      8'sh3D
`define OSM_GUARD_IN     8'sh39
`define OSM_GUARD_IN_N   8'shC7
`define OSM_GUARD_LO_OFS 8'sh3D
`define OSM_GUARD_HI_OFS 8'sh26
`define OSM_PH_INIT      4'h4
`define OSM_PH_WRAP      4'h9
`define OSM_N_GUARD      4'hA
`define OSM_N_PILOT      4'hC

// ----------------------------------------------------------------------------
// sign sequence, bit set means -1
// ----------------------------------------------------------------------------
`define OSM_PSEQ         127'h7F1D8A5F_542DE72B_306D7464_40934F70
`define OSM_SEQ_LAST     7'h7E
`define OSM_SPREAD_OFS   7'h06
`define OSM_SPREAD_WRAP  7'h79

// ----------------------------------------------------------------------------
// pilot patterns, bit set means negative component
// ----------------------------------------------------------------------------
`define OSM_PAT_A_RE     12'h6F6
`define OSM_PAT_A_IM     12'h6C9
`define OSM_PAT_B_RE     12'h6F6
`define OSM_PAT_B_IM     12'h6F6

`endif

// *** osm_pkg.sv ***
/*
  Types of the subcarrier mapper: controller states and tone classes.
  Assumes nothing of its surroundings.
*/
`default_nettype none

package osm_pkg;

    typedef enum logic [2:0] {
        OSM_IDLE = 3'h1,
        OSM_FILL = 3'h2,
        OSM_EMIT = 3'h4
    } osm_state_t;

    typedef enum logic [1:0] {
        OSM_TONE_DATA  = 2'h0,
        OSM_TONE_GUARD = 2'h1,
        OSM_TONE_PILOT = 2'h2,
        OSM_TONE_NULL  = 2'h3
    } osm_tone_t;

endpackage : osm_pkg

`default_nettype wire

// *** osm_stream_if.sv ***
/*
  Valid/ready carrier between the mapper core and its output FIFO.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface osm_stream_if #(parameter int W = 25);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;

    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : osm_stream_if

`default_nettype wire

// *** osm_fifo.sv ***
/*
  Flip-flop FIFO with valid/ready on both sides.
  Assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module osm_fifo
    import osm_pkg::*;
#(
    parameter int W     = 25,
    parameter int DEPTH = 8
)(
    input  wire logic   clk,
    input  wire logic   rst_b,
    osm_stream_if.snk   wr,
    osm_stream_if.src   rd
);
    localparam int AW = $clog2(DEPTH);

    logic [W-1:0] mem_q [DEPTH];
    logic [W-1:0] mem_d [DEPTH];
    logic [AW:0]  wp_q, wp_d;
    logic [AW:0]  rp_q, rp_d;
    logic         full;
    logic         empty;
    logic         do_wr;
    logic         do_rd;

    assign full     = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
    assign empty    = (wp_q == rp_q);
    assign wr.ready = !full;
    assign rd.valid = !empty;
    assign rd.data  = mem_q[rp_q[AW-1:0]];
    assign do_wr    = wr.valid && !full;
    assign do_rd    = rd.ready && !empty;

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < DEPTH; i++)
    begin : g_mem
        always_comb
        begin
            mem_d[i] = (do_wr && (wp_q[AW-1:0] == AW'(i))) ? wr.data : mem_q[i];
        end

        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
                mem_q[i] <= '0;
            else
                mem_q[i] <= mem_d[i];
        end
    end

    // ------------------------------------------------------------------------
    // pointers
    // ------------------------------------------------------------------------
    always_comb
    begin
        wp_d = do_wr ? wp_q + 1'b1 : wp_q;
        rp_d = do_rd ? rp_q + 1'b1 : rp_q;
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end

endmodule : osm_fifo

`default_nettype wire

// *** osm_mapper.sv ***
/*
  Transmit tone mapper: buffers 100 constellation values, emits each symbol's
  123 logical tones (-61..61) with data, guard copies, pilots and a null DC.
  Assumes upstream gives the symbol counts and rate with the start pulse and
  that the transform stage drains the output through valid/ready.
*/
`timescale 1ns/1ps
`default_nettype none
`include "osm_defines.svh"

// Notes on behaviour
// (R1) At the middle rates only time spreading is used, one group of 100 values feeds a pair of symbols.
// (R2) In a pair, tone l of the first symbol is value l, of the second value 99-l swapped and times the spread sign.
// (R3) At the highest rates each payload symbol takes 100 fresh values in order, without spreading.
// (R4) Every symbol carries ten guard tones, five at each edge of the band.
// (R5) The guard power relation is chosen per packet and held fixed until the packet ends.
// (R6) Guard tones sit at logical tones -61..-57 and 57..61.
// (R7) Guard entries 0..4 copy data tones 0..4 and entries 5..9 copy data tones 95..99.
// (R8) Every symbol carries twelve pilots at -55..55 in steps of 10, skipping zero.
// (R9) Header pilots are the sequence entry at the pair index times pattern A, the second symbol also times the spread sign.
// (R10) Pattern A is (1-j) on 0,3, (-1+j) on 1,2,4,5, (1+j) on 8,11 and (-1-j) on 6,7,9,10, all over root two.
// (R11) Middle-rate pilots follow the paired formula with pattern B, (1+j) on 0,3,8,11 and (-1-j) elsewhere.
// (R12) Highest-rate pilots use the per-symbol sequence entry times pattern B with no spread factor.
// (R13) The spread sign of a pair is the sequence entry six places after the pair's pilot entry, modulo 127.
// (R14) Symbol counts and rate class are taken with the start pulse and held for the whole packet.
// (R15) Tones leave in logical order and the mapper stalls while the transform stage cannot take them.
module osm_mapper
    import osm_pkg::*;
#(
    parameter int             DW         = 12,
    parameter int             CW         = 10,
    parameter int             FIFO_DEPTH = 8,
    parameter logic [DW-1:0]  PILOT_AMP  = 12'h2D4
)(
    input  wire logic          CLK_SYS,
    input  wire logic          RST_B,
    input  wire logic          PKT_START,
    input  wire logic [CW-1:0] HDR_SYMS,
    input  wire logic [CW-1:0] PAY_SYMS,
    input  wire logic          RATE_HIGH,
    input  wire logic [1:0]    GUARD_SHIFT,
    input  wire logic          IN_VALID,
    output logic               IN_READY,
    input  wire logic [DW-1:0] IN_RE,
    input  wire logic [DW-1:0] IN_IM,
    output logic               TONE_VALID,
    input  wire logic          TONE_READY,
    output logic [DW-1:0]      TONE_RE,
    output logic [DW-1:0]      TONE_IM,
    output logic               TONE_LAST,
    output logic               BUSY
);
    localparam int             FW   = 2 * DW + 1;
    localparam logic [126:0]   PSEQ = `OSM_PSEQ;
    localparam logic [11:0]    PAT_A_RE = `OSM_PAT_A_RE;
    localparam logic [11:0]    PAT_A_IM = `OSM_PAT_A_IM;
    localparam logic [11:0]    PAT_B_RE = `OSM_PAT_B_RE;
    localparam logic [11:0]    PAT_B_IM = `OSM_PAT_B_IM;

    osm_stream_if #(.W(FW)) push_if ();
    osm_stream_if #(.W(FW)) pop_if ();

    osm_state_t       st_q, st_d;
    logic signed [7:0] tone_q, tone_d;
    logic [3:0]       ph_q, ph_d;
    logic [3:0]       pidx_q, pidx_d;
    logic [3:0]       gcnt_q, gcnt_d;
    logic [6:0]       dcnt_q, dcnt_d;
    logic [6:0]       fill_q, fill_d;
    logic [6:0]       ptr_q, ptr_d;
    logic [CW-1:0]    left_q, left_d;
    logic [CW-1:0]    hdr_q, hdr_d;
    logic [CW-1:0]    pay_q, pay_d;
    logic             odd_q, odd_d;
    logic             stg_hdr_q, stg_hdr_d;
    logic             rate_q, rate_d;
    logic [1:0]       gsh_q, gsh_d;
    logic [2*DW-1:0]  buf_q [`OSM_N_DATA];
    logic [2*DW-1:0]  buf_d [`OSM_N_DATA];

    osm_tone_t        cls;
    logic             push;
    logic             sym_end;
    logic             mode_mid;
    logic             rev;
    logic             spread_sym;
    logic [6:0]       sptr;
    logic signed [7:0] gsum;
    logic [6:0]       lidx;
    logic [6:0]       ridx;
    logic [2*DW-1:0]  rd;
    logic [DW-1:0]    push_re;
    logic [DW-1:0]    push_im;
    logic             p_neg_re;
    logic             p_neg_im;

    // ------------------------------------------------------------------------
    // tone classification and value
    // ------------------------------------------------------------------------
    assign mode_mid   = !stg_hdr_q && !rate_q;
    assign rev        = odd_q && mode_mid;                                    // [R2]
    assign spread_sym = odd_q && (stg_hdr_q || mode_mid);                     // [R9] [R11]
    assign sptr       = (ptr_q >= `OSM_SPREAD_WRAP) ? ptr_q - `OSM_SPREAD_WRAP
                                                    : ptr_q + `OSM_SPREAD_OFS; // [R13]
    assign push       = (st_q == OSM_EMIT) && push_if.ready;                  // [R15]
    assign sym_end    = push && (tone_q == `OSM_TONE_HI);
    assign gsum       = tone_q + ((tone_q < 0) ? `OSM_GUARD_LO_OFS : `OSM_GUARD_HI_OFS);

    always_comb
    begin
        if (tone_q >= `OSM_GUARD_IN || tone_q <= `OSM_GUARD_IN_N)
            cls = OSM_TONE_GUARD;                                             // [R4] [R6]
        else if (tone_q == 8'sh00)
            cls = OSM_TONE_NULL;
        else if (ph_q == 4'h0)
            cls = OSM_TONE_PILOT;                                             // [R8]
        else
            cls = OSM_TONE_DATA;
    end

    always_comb
    begin
        lidx     = (cls == OSM_TONE_GUARD) ? gsum[6:0] : dcnt_q;              // [R7]
        ridx     = rev ? `OSM_DATA_LAST - lidx : lidx;                        // [R2]
        rd       = buf_q[ridx];
        p_neg_re = (stg_hdr_q ? PAT_A_RE[pidx_q] : PAT_B_RE[pidx_q])           // [R10] [R11]
                   ^ PSEQ[ptr_q] ^ (spread_sym & PSEQ[sptr]);                  // [R9] [R12]
        p_neg_im = (stg_hdr_q ? PAT_A_IM[pidx_q] : PAT_B_IM[pidx_q])
                   ^ PSEQ[ptr_q] ^ (spread_sym & PSEQ[sptr]);
        push_re  = rd[2*DW-1:DW];
        push_im  = rd[DW-1:0];
        if (rev)
        begin
            push_re = PSEQ[sptr] ? -rd[DW-1:0] : rd[DW-1:0];                  // [R2] [R13]
            push_im = PSEQ[sptr] ? -rd[2*DW-1:DW] : rd[2*DW-1:DW];
        end
        unique case (cls)
            OSM_TONE_GUARD:
            begin
                push_re = $signed(push_re) >>> gsh_q;                         // [R5] [R7]
                push_im = $signed(push_im) >>> gsh_q;
            end
            OSM_TONE_PILOT:
            begin
                push_re = p_neg_re ? -PILOT_AMP : PILOT_AMP;
                push_im = p_neg_im ? -PILOT_AMP : PILOT_AMP;
            end
            OSM_TONE_NULL:
            begin
                push_re = '0;
                push_im = '0;
            end
            OSM_TONE_DATA:
            begin
                push_re = push_re;
                push_im = push_im;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // data buffer
    // ------------------------------------------------------------------------
    for (genvar i = 0; i < `OSM_N_DATA; i++)
    begin : g_buf
        always_comb
        begin
            buf_d[i] = (IN_READY && IN_VALID && fill_q == 7'(i)) ? {IN_RE, IN_IM} : buf_q[i]; // [R1] [R3]
        end

        always_ff @(posedge CLK_SYS or negedge RST_B)
        begin
            if (!RST_B)
                buf_q[i] <= '0;
            else
                buf_q[i] <= buf_d[i];
        end
    end

    // ------------------------------------------------------------------------
    // controller
    // ------------------------------------------------------------------------
    always_comb
    begin
        st_d = st_q;  tone_d = tone_q;  ph_d = ph_q;  pidx_d = pidx_q;  gcnt_d = gcnt_q;
        dcnt_d = dcnt_q;  fill_d = fill_q;  ptr_d = ptr_q;  left_d = left_q;  hdr_d = hdr_q;
        pay_d = pay_q;  odd_d = odd_q;  stg_hdr_d = stg_hdr_q;  rate_d = rate_q;  gsh_d = gsh_q;
        unique case (st_q)
            OSM_IDLE:
            begin
                if (PKT_START && (HDR_SYMS != '0 || PAY_SYMS != '0))
                begin
                    hdr_d     = HDR_SYMS;                                     // [R14]
                    pay_d     = PAY_SYMS;
                    rate_d    = RATE_HIGH;
                    gsh_d     = GUARD_SHIFT;                                  // [R5]
                    stg_hdr_d = (HDR_SYMS != '0);
                    left_d    = (HDR_SYMS != '0) ? HDR_SYMS : PAY_SYMS;
                    ptr_d     = '0;
                    odd_d     = 1'b0;
                    fill_d    = '0;
                    st_d      = OSM_FILL;
                end
            end
            OSM_FILL:
            begin
                if (IN_VALID)
                begin
                    fill_d = fill_q + 7'h01;
                    if (fill_q == `OSM_DATA_LAST)
                        st_d = OSM_EMIT;
                end
            end
            OSM_EMIT:
            begin
                if (push)
                begin
                    tone_d = tone_q + 8'sh01;                                 // [R15]
                    ph_d   = (ph_q == `OSM_PH_WRAP) ? 4'h0 : ph_q + 4'h1;
                    if (cls == OSM_TONE_PILOT)
                        pidx_d = pidx_q + 4'h1;
                    if (cls == OSM_TONE_DATA)
                        dcnt_d = dcnt_q + 7'h01;
                    if (cls == OSM_TONE_GUARD)
                        gcnt_d = gcnt_q + 4'h1;
                end
                if (sym_end)
                begin
                    fill_d = '0;
                    if (mode_mid && !odd_q)
                    begin
                        odd_d  = 1'b1;                                        // [R1]
                        left_d = left_q - 1'b1;
                    end
                    else
                    begin
                        odd_d = !odd_q;
                        if (!(stg_hdr_q && !odd_q))
                            ptr_d = (ptr_q == `OSM_SEQ_LAST) ? 7'h00 : ptr_q + 7'h01; // [R9] [R12]
                        left_d = left_q - 1'b1;
                        st_d   = OSM_FILL;                                    // [R3]
                        if (left_q == CW'(1))
                        begin
                            if (stg_hdr_q && pay_q != '0)
                            begin
                                stg_hdr_d = 1'b0;
                                left_d    = pay_q;
                                odd_d     = 1'b0;
                            end
                            else
                                st_d = OSM_IDLE;
                        end
                    end
                end
            end
            default:
                st_d = OSM_IDLE;
        endcase
        if (st_d == OSM_EMIT && (st_q != OSM_EMIT || sym_end))
        begin
            tone_d = `OSM_TONE_LO;
            ph_d   = `OSM_PH_INIT;
            pidx_d = '0;
            gcnt_d = '0;
            dcnt_d = '0;
        end
    end

    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
        begin
            st_q <= OSM_IDLE;  tone_q <= `OSM_TONE_LO;  ph_q <= `OSM_PH_INIT;  pidx_q <= '0;
            gcnt_q <= '0;  dcnt_q <= '0;  fill_q <= '0;  ptr_q <= '0;  left_q <= '0;
            hdr_q <= '0;  pay_q <= '0;  odd_q <= 1'b0;  stg_hdr_q <= 1'b0;  rate_q <= 1'b0;
            gsh_q <= '0;
        end
        else
        begin
            st_q <= st_d;  tone_q <= tone_d;  ph_q <= ph_d;  pidx_q <= pidx_d;
            gcnt_q <= gcnt_d;  dcnt_q <= dcnt_d;  fill_q <= fill_d;  ptr_q <= ptr_d;
            left_q <= left_d;  hdr_q <= hdr_d;  pay_q <= pay_d;  odd_q <= odd_d;
            stg_hdr_q <= stg_hdr_d;  rate_q <= rate_d;  gsh_q <= gsh_d;
        end
    end

    // ------------------------------------------------------------------------
    // output path
    // ------------------------------------------------------------------------
    assign IN_READY       = (st_q == OSM_FILL);                               // [R1] [R3]
    assign BUSY           = (st_q != OSM_IDLE);
    assign push_if.valid  = (st_q == OSM_EMIT);
    assign push_if.data   = {sym_end, push_re, push_im};
    assign pop_if.ready   = TONE_READY;
    assign TONE_VALID     = pop_if.valid;
    assign {TONE_LAST, TONE_RE, TONE_IM} = pop_if.data;

    osm_fifo #(
        .W     (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk   (CLK_SYS),
        .rst_b (RST_B),
        .wr    (push_if.snk),
        .rd    (pop_if.src)
    );

    // ------------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_B);

    sequence s_sym_end;
        push && tone_q == `OSM_TONE_HI;
    endsequence

    sequence s_mid_first_end;
        s_sym_end ##0 (mode_mid && !odd_q);
    endsequence

    property p_mid_pair;
        s_mid_first_end |=> (st_q == OSM_EMIT && odd_q && tone_q == `OSM_TONE_LO);
    endproperty
    a_mid_pair: assert property (p_mid_pair) else $error("second symbol of pair not emitted"); // [R1]

    property p_mid_no_take;
        (st_q == OSM_EMIT && odd_q && mode_mid) |-> !IN_READY;
    endproperty
    a_mid_no_take: assert property (p_mid_no_take) else $error("input taken in second symbol"); // [R1]

    property p_swap;
        (push && rev && cls == OSM_TONE_DATA && dcnt_q == 7'h00 && !PSEQ[sptr])
            |-> push_re == buf_q[`OSM_N_DATA - 1][DW-1:0];
    endproperty
    a_swap: assert property (p_swap) else $error("second symbol tone 0 not swapped value 99"); // [R2]

    property p_high_fill;
        (s_sym_end ##0 (!stg_hdr_q && rate_q && left_q != CW'(1))) |=> (st_q == OSM_FILL && fill_q == 7'h00);
    endproperty
    a_high_fill: assert property (p_high_fill) else $error("high rate symbol not refilled"); // [R3]

    property p_ten_guards;
        s_sym_end |-> gcnt_q == `OSM_N_GUARD - 4'h1;
    endproperty
    a_ten_guards: assert property (p_ten_guards) else $error("guard count per symbol wrong"); // [R4] [R6]

    property p_guard_copy;
        (push && tone_q == `OSM_TONE_LO && !rev) |-> push_re == DW'($signed(buf_q[0][2*DW-1:DW]) >>> gsh_q);
    endproperty
    a_guard_copy: assert property (p_guard_copy) else $error("guard 0 not a copy of data 0"); // [R7]

    property p_twelve_pilots;
        s_sym_end |-> pidx_q == `OSM_N_PILOT;
    endproperty
    a_twelve_pilots: assert property (p_twelve_pilots) else $error("pilot count per symbol wrong"); // [R8]

    property p_hdr_pilot;
        (push && cls == OSM_TONE_PILOT && stg_hdr_q && pidx_q == 4'h1 && !odd_q) |-> push_re[DW-1] == !PSEQ[ptr_q];
    endproperty
    a_hdr_pilot: assert property (p_hdr_pilot) else $error("header pilot 1 sign wrong"); // [R9] [R10]

    property p_mid_pilot;
        (push && cls == OSM_TONE_PILOT && mode_mid && pidx_q == 4'h1 && odd_q)
            |-> push_re[DW-1] == !(PSEQ[ptr_q] ^ PSEQ[sptr]);
    endproperty
    a_mid_pilot: assert property (p_mid_pilot) else $error("middle rate pilot sign wrong"); // [R11]

    property p_high_pilot;
        (push && cls == OSM_TONE_PILOT && !stg_hdr_q && rate_q && pidx_q == 4'h0) |-> push_re[DW-1] == PSEQ[ptr_q];
    endproperty
    a_high_pilot: assert property (p_high_pilot) else $error("high rate pilot sign wrong"); // [R12]

    property p_spread_ptr;
        int'(sptr) == (int'(ptr_q) + 6) % 127;
    endproperty
    a_spread_ptr: assert property (p_spread_ptr) else $error("spread index offset wrong"); // [R13]

    property p_params_held;
        (st_q != OSM_IDLE && st_d != OSM_IDLE) |=> ($stable(hdr_q) && $stable(rate_q) && $stable(gsh_q));
    endproperty
    a_params_held: assert property (p_params_held) else $error("packet parameters changed"); // [R5] [R14]

    property p_stall;
        (st_q == OSM_EMIT && !push_if.ready) |=> $stable(tone_q);
    endproperty
    a_stall: assert property (p_stall) else $error("tone advanced while stalled"); // [R15]

endmodule : osm_mapper

`default_nettype wire

// *** osm_tone_sink.sv ***
/*
  Downstream transform stage model: takes tones, stalls at random.
  Assumes one clock and an active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none

module osm_tone_sink (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic stall_en,
    output logic      ready
);
    // ready drops now and then while stalls are allowed
    always @(posedge clk or negedge rst_b)
        if (!rst_b)
            ready <= 1'b0;
        else
            ready <= #1 !(stall_en && ($urandom_range(0, 3) == 0));
endmodule : osm_tone_sink

`default_nettype wire

// *** testbench.sv ***
/*
  Self-checking bench of the tone mapper with a queue model of each symbol.
  Assumes the mapper, its FIFO and the sink model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`include "osm_defines.svh"

module testbench
    import osm_pkg::*;
;
    // ------------------------------------------------------------------
    // model and stimulus
    // ------------------------------------------------------------------
    localparam logic [126:0] PS = `OSM_PSEQ;
    localparam logic [11:0]  PA_RE = 12'h6F6, PA_IM = 12'h6C9, PB = 12'h6F6;
    logic        clk_sys = 1'b0, rst_b = 1'b0, pkt_start = 1'b0, rate_high = 1'b0;
    logic        in_valid = 1'b0, stall_en = 1'b0;
    logic [9:0]  hdr_syms = '0, pay_syms = '0;
    logic [1:0]  guard_shift = '0, gsh;
    logic [11:0] in_re = '0, in_im = '0, tone_re, tone_im, g_re[100], g_im[100];
    logic        in_ready, tone_valid, tone_ready, tone_last, busy;
    logic [24:0] exp_q[$];
    int          bad_count = 0, total_checks = 0;

    always #2.5 clk_sys = ~clk_sys;

    osm_mapper dut (.CLK_SYS(clk_sys), .RST_B(rst_b), .PKT_START(pkt_start), .HDR_SYMS(hdr_syms),
        .PAY_SYMS(pay_syms), .RATE_HIGH(rate_high), .GUARD_SHIFT(guard_shift), .IN_VALID(in_valid),
        .IN_READY(in_ready), .IN_RE(in_re), .IN_IM(in_im), .TONE_VALID(tone_valid),
        .TONE_READY(tone_ready), .TONE_RE(tone_re), .TONE_IM(tone_im), .TONE_LAST(tone_last), .BUSY(busy));
    osm_tone_sink sink (.clk(clk_sys), .rst_b(rst_b), .stall_en(stall_en), .ready(tone_ready));

    function automatic logic [11:0] neg(logic [11:0] v, logic n);
        return n ? 12'(-v) : v;
    endfunction : neg

    task automatic close_out();
        if (bad_count == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out

    task automatic check(logic [1:0] got, logic [1:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR %0t flags %b want %b", $time, got, exp);
        end
    endtask : check

    task automatic chk_tone();
        logic [24:0] e;
        total_checks++;
        e = (exp_q.size() > 0) ? exp_q.pop_front() : 'x;
        if ({tone_last, tone_re, tone_im} !== e)
        begin
            bad_count++;
            $display("ERROR %0t tone %h want %h", $time, {tone_last, tone_re, tone_im}, e);
        end
    endtask : chk_tone

    always @(posedge clk_sys)
        if (rst_b && tone_valid === 1'b1 && tone_ready === 1'b1)
            chk_tone();

    task automatic push_sym(logic pn, logic swp, logic dn, logic [11:0] pre, logic [11:0] pim);
        logic [11:0] d_re[100], d_im[100], r, i;
        int          k, n;
        n = 0;
        for (k = 0; k < 100; k++)
        begin
            d_re[k] = neg(swp ? g_im[99 - k] : g_re[k], dn);
            d_im[k] = neg(swp ? g_re[99 - k] : g_im[k], dn);
        end
        for (k = -61; k <= 61; k++)
        begin
            if (k < -56 || k > 56)
            begin
                r = 12'($signed(d_re[k < 0 ? k + 61 : k + 38]) >>> gsh);
                i = 12'($signed(d_im[k < 0 ? k + 61 : k + 38]) >>> gsh);
            end
            else if (k % 10 == 5 || k % 10 == -5)
            begin
                r = neg(12'h2D4, pre[(k + 55) / 10] ^ pn);
                i = neg(12'h2D4, pim[(k + 55) / 10] ^ pn);
            end
            else
            begin
                r = (k == 0) ? 12'h000 : d_re[n];
                i = (k == 0) ? 12'h000 : d_im[n];
                n += (k != 0);
            end
            exp_q.push_back({k == 61, r, i});
        end
    endtask : push_sym

    task automatic fill();
        int n;
        for (n = 0; n < 100; n++)
        begin
            g_re[n] = 12'($urandom);
            g_im[n] = 12'($urandom) & 12'h7FF;
            in_valid <= 1'b1;
            in_re <= g_re[n];
            in_im <= g_im[n];
            do @(posedge clk_sys); while (in_ready !== 1'b1);
            #1;
        end
    endtask : fill

    task automatic run_pkt(int h, int p, logic hi, logic [1:0] gs);
        int j, q;
        check({busy, in_ready}, 2'b00);
        {hdr_syms, pay_syms, rate_high, guard_shift, pkt_start} <= {10'(h), 10'(p), hi, gs, 1'b1};
        gsh = gs;
        @(posedge clk_sys);
        #1;
        pkt_start <= 1'b0;
        {hdr_syms, pay_syms, rate_high, guard_shift} <= 23'($urandom);
        for (j = 0; j < h; j++)
        begin
            fill();
            push_sym(PS[j / 2] ^ (j[0] & PS[j / 2 + 6]), 1'b0, 1'b0, PA_RE, PA_IM);
        end
        q = h / 2;
        for (j = 0; j < p; j += hi ? 1 : 2)
        begin
            fill();
            push_sym(PS[q], 1'b0, 1'b0, PB, PB);
            if (!hi)
                push_sym(PS[q] ^ PS[q + 6], 1'b1, PS[q + 6], PB, PB);
            q++;
        end
        in_valid <= 1'b0;
        repeat (2000) if (exp_q.size() != 0) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
        #1;
        check({busy, exp_q.size() != 0}, 2'b00);
    endtask : run_pkt

    initial
    begin
        void'($urandom(44));
        repeat (12) @(posedge clk_sys);
        #1;
        rst_b = 1'b1;
        stall_en = 1'b1;
        run_pkt(2, 2, 1'b0, 2'h1);
        run_pkt(2, 3, 1'b1, 2'h3);
        stall_en = 1'b0;
        run_pkt(4, 4, 1'b0, 2'h0);
        close_out();
    end

    initial
    begin
        repeat (40000) @(posedge clk_sys);
        bad_count++;
        close_out();
    end
endmodule : testbench

`default_nettype wire
